// ===== src/tcpu_pkg.sv
// Shared constants for the pixel unpacker, plus its input synchroniser.
package tcpu_pkg;
    // Register byte addresses.
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] MASK_ADDR = 12'h004;
    localparam logic [11:0] STAT_ADDR = 12'h008;
    localparam logic [11:0] DAC_ADDR = 12'h00C;
    localparam logic [11:0] OVL_BASE = 12'h040;
    localparam logic [11:0] PAL_BASE = 12'h400;
    // Field positions.
    localparam int MODE_LSB = 5;
    localparam int MODE_MSB = 7;
    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hFF;
    // Fixed latency in pixel clocks.
    localparam int PIPE_DEPTH = 4;
    // Colour modes by the mode field value.
    localparam logic [2:0] MODE_SC15 = 3'h4;
    localparam logic [2:0] MODE_TC15 = 3'h5;
    localparam logic [2:0] MODE_TC16 = 3'h6;
    localparam logic [2:0] MODE_TC24 = 3'h7;
    // AHB transfer type.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // Byte slot within a multi-clock pixel, Gray coded.
    typedef enum logic [1:0] {
        SLOT_0 = 2'b00,
        SLOT_1 = 2'b01,
        SLOT_2 = 2'b11
    } tcpu_slot_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for pins from outside the hclk domain.
module tcpu_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Asynchronous in, synchronous out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

`default_nettype wire

// ===== src/tcpu_unpacker.sv
// Pixel port front end: mode select, byte assembly, palette, overlay, fixed pipeline.
//
// How it works
// - Mode field picks pseudo, 15, 16, 24-bit.
// - Four pixel clocks capture to DAC inputs.
// - True colour bypasses palette and mask.
// - Overlay colour beats palette in pseudocolour.
// - Modulo two/three counter makes load pulse.
// - Blanking clears the modulo counter.
// - Pseudocolour index taken each rising edge.
// - Mode 4: low rising, high falling.
// - 15-bit: red 14:10, green 9:5, blue 4:0.
// - Short components left aligned, zero filled.
// - Single-clock 15-bit updates every clock.
// - Two-clock first low byte at unblank edge.
// - Low/high alternate until blanking returns.
// - 16-bit: red 15:11, green 10:5, blue 4:0.
// - Two-clock modes update every second clock.
// - 24-bit blue byte taken at unblank edge.
// - 24-bit bytes come blue, green, red.
// - 24-bit mode updates every third clock.
// - Pixel ANDed with mask before lookup.
`timescale 1ns/1ps
`default_nettype none

module tcpu_unpacker #(
    parameter int PAL_ENTRIES = 256,
    parameter int OVL_ENTRIES = 15
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pixel port from the graphics controller.
    input wire logic pixel_clk,
    input wire logic blank_n,
    input wire logic [7:0] pixel_in,
    input wire logic [3:0] overlay_sel,
    // DAC input words.
    output logic [7:0] dac_red,
    output logic [7:0] dac_green,
    output logic [7:0] dac_blue,
    output logic dac_load
);
    // Synchronised pins.
    logic pclk_s;
    logic blank_n_s;
    logic [7:0] pix_s;
    logic [3:0] ovl_s;
    logic pclk_prev_q;
    logic rise;
    logic fall;

    // Registers and storage.
    logic [7:0] control_reg_q;
    logic [7:0] pixel_mask_reg_q;
    logic [23:0] pal_q [PAL_ENTRIES];
    logic [23:0] ovl_q [OVL_ENTRIES];
    logic [2:0] color_mode_field;

    // Assembly state.
    tcpu_pkg::tcpu_slot_t slot_q;
    logic [7:0] byte0_q;
    logic [7:0] byte1_q;
    logic [7:0] hi_fall_q;
    logic [7:0] lo_rise_q;
    logic lo_act_q;

    // Pipeline.
    localparam int PIPE_STAGES = tcpu_pkg::PIPE_DEPTH;
    logic [23:0] pipe_rgb_q [PIPE_STAGES];
    logic [PIPE_STAGES-1:0] pipe_vld_q;
    logic [23:0] new_rgb;
    logic new_vld;

    // Bus state.
    logic wr_pend_q;
    logic rd_pend_q;
    logic [11:0] addr_q;
    logic [31:0] rd_mux;
    logic addr_ok;

    tcpu_sync #(.WIDTH(14)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({pixel_clk, blank_n, pixel_in, overlay_sel}),
        .sync_out({pclk_s, blank_n_s, pix_s, ovl_s})
    );

    // Edge finder on the synchronised pixel clock.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pclk_prev_q <= 1'b0;
        end else begin
            pclk_prev_q <= pclk_s;
        end
    end

    assign rise = pclk_s & ~pclk_prev_q;
    assign fall = ~pclk_s & pclk_prev_q;

    // No pin path: only the register selects a mode.
    assign color_mode_field = control_reg_q[tcpu_pkg::MODE_MSB:tcpu_pkg::MODE_LSB];

    // High byte taken on the falling edge in single-clock 15-bit mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_fall_q <= 8'h00;
        end else if (fall) begin
            hi_fall_q <= pix_s;
        end
    end

    // Modulo byte counter; it also keeps the captured bytes.
    // Blanking holds the counter at the first slot.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_q <= tcpu_pkg::SLOT_0;
            byte0_q <= 8'h00;
            byte1_q <= 8'h00;
            lo_rise_q <= 8'h00;
            lo_act_q <= 1'b0;
        end else if (rise) begin
            lo_rise_q <= pix_s;
            // Remembers whether the low byte's edge lay outside blanking.
            lo_act_q <= blank_n_s;
            if (!blank_n_s) begin
                slot_q <= tcpu_pkg::SLOT_0;
            end else begin
                case (slot_q)
                    tcpu_pkg::SLOT_0: begin
                        // First byte taken at the unblank edge.
                        byte0_q <= pix_s;
                        if (color_mode_field == tcpu_pkg::MODE_TC15
                                || color_mode_field == tcpu_pkg::MODE_TC16
                                || color_mode_field == tcpu_pkg::MODE_TC24) begin
                            slot_q <= tcpu_pkg::SLOT_1;
                        end
                    end
                    tcpu_pkg::SLOT_1: begin
                        byte1_q <= pix_s;
                        // Two-clock modes wrap after the high byte.
                        if (color_mode_field == tcpu_pkg::MODE_TC24) begin
                            slot_q <= tcpu_pkg::SLOT_2;
                        end else begin
                            slot_q <= tcpu_pkg::SLOT_0;
                        end
                    end
                    tcpu_pkg::SLOT_2: begin
                        slot_q <= tcpu_pkg::SLOT_0;
                    end
                    default: begin
                        slot_q <= tcpu_pkg::SLOT_0;
                    end
                endcase
            end
        end
    end

    // Word formatting and load pulse for the current rising edge.
    always_comb begin
        logic [7:0] idx;
        logic [15:0] word;
        idx = 8'h00;
        word = 16'h0000;
        new_rgb = 24'h000000;
        new_vld = 1'b0;
        if (!blank_n_s) begin
            // Blanking sends black through the pipe.
            new_rgb = 24'h000000;
            new_vld = 1'b1;
        end else if (!color_mode_field[2]) begin
            // Every rising edge gives an index.
            idx = pix_s & pixel_mask_reg_q;
            new_vld = 1'b1;
            if (ovl_s != 4'h0) begin
                new_rgb = ovl_q[ovl_s - 4'h1];
            end else begin
                new_rgb = pal_q[idx];
            end
        end else begin
            // True colour skips palette and mask.
            case (color_mode_field)
                tcpu_pkg::MODE_SC15: begin
                    // A word every clock, from the previous clock.
                    word = lo_act_q ? {hi_fall_q, lo_rise_q} : 16'h0000;
                    new_vld = 1'b1;
                end
                tcpu_pkg::MODE_TC15, tcpu_pkg::MODE_TC16: begin
                    // Load only on the high byte edge.
                    word = {pix_s, byte0_q};
                    new_vld = (slot_q == tcpu_pkg::SLOT_1);
                end
                default: begin
                    word = 16'h0000;
                    // Load only on the red byte edge.
                    new_vld = (slot_q == tcpu_pkg::SLOT_2);
                end
            endcase
            if (color_mode_field == tcpu_pkg::MODE_TC16) begin
                new_rgb = {word[15:11], 3'b000, word[10:5], 2'b00, word[4:0], 3'b000};
            end else if (color_mode_field == tcpu_pkg::MODE_TC24) begin
                // Red now, green and blue held earlier.
                new_rgb = {pix_s, byte1_q, byte0_q};
            end else begin
                // Field layout 5-5-5, top bit dropped.
                new_rgb = {word[14:10], 3'b000, word[9:5], 3'b000, word[4:0], 3'b000};
            end
        end
    end

    // Pipeline advanced by rising pixel clock edges.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pipe_vld_q <= '0;
            for (int i = 0; i < PIPE_STAGES; i++) begin
                pipe_rgb_q[i] <= 24'h000000;
            end
        end else if (rise) begin
            pipe_rgb_q[0] <= new_rgb;
            pipe_vld_q[0] <= new_vld;
            for (int i = 1; i < PIPE_STAGES; i++) begin
                pipe_rgb_q[i] <= pipe_rgb_q[i-1];
                pipe_vld_q[i] <= pipe_vld_q[i-1];
            end
        end
    end

    // DAC input registers take the last stage on its load pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_red <= 8'h00;
            dac_green <= 8'h00;
            dac_blue <= 8'h00;
            dac_load <= 1'b0;
        end else begin
            dac_load <= 1'b0;
            if (rise && pipe_vld_q[PIPE_STAGES-1]) begin
                dac_red <= pipe_rgb_q[PIPE_STAGES-1][23:16];
                dac_green <= pipe_rgb_q[PIPE_STAGES-1][15:8];
                dac_blue <= pipe_rgb_q[PIPE_STAGES-1][7:0];
                dac_load <= 1'b1;
            end
        end
    end

    // Address phase capture; reads get one wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans == tcpu_pkg::HTRANS_NONSEQ && hwrite;
            rd_pend_q <= hsel && htrans == tcpu_pkg::HTRANS_NONSEQ && !hwrite;
            addr_q <= haddr[11:0];
        end else begin
            rd_pend_q <= 1'b0;
        end
    end

    assign hreadyout = ~rd_pend_q;
    assign hresp = 1'b0;

    // Control and mask registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg_q <= tcpu_pkg::CTRL_RST;
            pixel_mask_reg_q <= tcpu_pkg::MASK_RST;
        end else if (wr_pend_q) begin
            if (addr_q == tcpu_pkg::CTRL_ADDR) begin
                control_reg_q <= hwdata[7:0];
            end
            if (addr_q == tcpu_pkg::MASK_ADDR) begin
                pixel_mask_reg_q <= hwdata[7:0];
            end
        end
    end

    // Palette and overlay storage, written word by word.
    always_ff @(posedge hclk) begin
        if (wr_pend_q) begin
            for (int i = 0; i < PAL_ENTRIES; i++) begin
                if (addr_q == tcpu_pkg::PAL_BASE + 12'(4 * i)) begin
                    pal_q[i] <= hwdata[23:0];
                end
            end
            for (int i = 0; i < OVL_ENTRIES; i++) begin
                if (addr_q == tcpu_pkg::OVL_BASE + 12'(4 * i)) begin
                    ovl_q[i] <= hwdata[23:0];
                end
            end
        end
    end

    // Read multiplexer; unmapped words read zero.
    always_comb begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b0;
        case (addr_q)
            tcpu_pkg::CTRL_ADDR: rd_mux = {24'h000000, control_reg_q};
            tcpu_pkg::MASK_ADDR: rd_mux = {24'h000000, pixel_mask_reg_q};
            tcpu_pkg::STAT_ADDR: rd_mux = {27'h0000000, blank_n_s, slot_q, color_mode_field[2],
                                           pipe_vld_q[PIPE_STAGES-1]};
            tcpu_pkg::DAC_ADDR: rd_mux = {8'h00, dac_red, dac_green, dac_blue};
            default: begin
                for (int i = 0; i < PAL_ENTRIES; i++) begin
                    if (addr_q == tcpu_pkg::PAL_BASE + 12'(4 * i)) begin
                        rd_mux = {8'h00, pal_q[i]};
                        addr_ok = 1'b1;
                    end
                end
                for (int i = 0; i < OVL_ENTRIES; i++) begin
                    if (!addr_ok && addr_q == tcpu_pkg::OVL_BASE + 12'(4 * i)) begin
                        rd_mux = {8'h00, ovl_q[i]};
                    end
                end
            end
        endcase
    end

    // Read data registered during the wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend_q) begin
            hrdata <= rd_mux;
        end
    end
endmodule

`default_nettype wire

// ===== test/tcpu_unpacker_sva.sv
// Bus and DAC-side checks for the pixel unpacker.
`timescale 1ns/1ps
`default_nettype none
module tcpu_unpacker_sva (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus handshake.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pixel side.
    input wire logic blank_n,
    input wire logic [7:0] dac_red,
    input wire logic [7:0] dac_green,
    input wire logic [7:0] dac_blue,
    input wire logic dac_load
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_req, wr_req;
    logic [7:0] blank_cnt_q, gap_q;
    // Decodes the accepted address phases.
    assign rd_req = hsel && hready && htrans == tcpu_pkg::HTRANS_NONSEQ && !hwrite;
    assign wr_req = hsel && hready && htrans == tcpu_pkg::HTRANS_NONSEQ && hwrite;
    // Counts blanking length and cycles since the last load, both saturating.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blank_cnt_q <= 8'h00;
            gap_q <= 8'hFF;
        end else begin
            blank_cnt_q <= blank_n ? 8'h00 : blank_cnt_q + 8'(blank_cnt_q != 8'hFF);
            gap_q <= dac_load ? 8'h00 : gap_q + 8'(gap_q != 8'hFF);
        end
    end
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response was not OKAY");
    chk_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
        else $error("read did not wait exactly one cycle");
    chk_write_nowait: assert property (wr_req |=> hreadyout)
        else $error("write data phase was stalled");
    chk_wait_cause: assert property (!hreadyout |-> $past(rd_req))
        else $error("wait state without a read");
    chk_load_pulse: assert property (dac_load |=> !dac_load)
        else $error("load pulse longer than one cycle");
    chk_dac_hold: assert property (!dac_load |-> $stable({dac_red, dac_green, dac_blue}))
        else $error("DAC words moved without a load");
    chk_blank_black: assert property (blank_cnt_q == 8'hFF && dac_load |->
        {dac_red, dac_green, dac_blue} == 24'h0) else $error("DAC words not black in blanking");
    chk_load_gap: assert property (dac_load |-> gap_q >= 8'h0C)
        else $error("more than one load per pixel clock");
    cover property (rd_req);
    cover property (dac_load && blank_n);
    cover property (blank_cnt_q == 8'hFF && dac_load);
endmodule
bind tcpu_unpacker tcpu_unpacker_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .blank_n(blank_n), .dac_red(dac_red), .dac_green(dac_green), .dac_blue(dac_blue),
    .dac_load(dac_load));
`default_nettype wire

// ===== test/tcpu_gfx_model.sv
// Graphics controller model driving the pixel port.
`timescale 1ns/1ps
`default_nettype none
module tcpu_gfx_model (
    // Pixel port.
    output logic pixel_clk,
    output logic blank_n,
    output logic [7:0] pixel_in,
    output logic [3:0] overlay_sel
);
    // Starts in blanking.
    initial begin
        pixel_clk = 1'b0;
        blank_n = 1'b0;
        pixel_in = 8'h00;
        overlay_sel = 4'h0;
    end
    // A video clock runs all the time, so blanking edges keep clearing the counter.
    always #32 pixel_clk = ~pixel_clk;
    // Sends one active line; bytes are set up a quarter period before their edge.
    task automatic send(input logic [7:0] b[$], input bit dual, input logic [3:0] ovl);
        for (int i = 0; i < b.size(); i++) begin
            if (dual && i % 2 == 1) @(posedge pixel_clk);
            else @(negedge pixel_clk);
            #16;
            blank_n = 1'b1;
            overlay_sel = ovl;
            pixel_in = b[i];
        end
        // Lets the last single-clock word be pushed before blanking returns.
        if (dual) begin
            @(negedge pixel_clk);
            #16;
            pixel_in = ~pixel_in;
        end
        // Blanking with the port toggling, so no stale byte looks valid.
        repeat (20) begin
            @(negedge pixel_clk);
            #16;
            blank_n = 1'b0;
            overlay_sel = 4'h0;
            pixel_in = ~pixel_in;
        end
    endtask
endmodule
`default_nettype wire

// ===== test/tcpu_unpacker_tb.sv
// Self-checking bench for the pixel unpacker.
`timescale 1ns/1ps
`default_nettype none
module tcpu_unpacker_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dac_load;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] dac_red, dac_green, dac_blue;
    wire logic pixel_clk, blank_n;
    wire logic [7:0] pixel_in;
    wire logic [3:0] overlay_sel;
    int fails = 0;
    int n_compared = 0;
    logic [23:0] got[$];
    tcpu_unpacker DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pixel_clk(pixel_clk),
        .blank_n(blank_n), .pixel_in(pixel_in), .overlay_sel(overlay_sel),
        .dac_red(dac_red), .dac_green(dac_green), .dac_blue(dac_blue), .dac_load(dac_load));
    tcpu_gfx_model gfx (.pixel_clk(pixel_clk), .blank_n(blank_n), .pixel_in(pixel_in),
        .overlay_sel(overlay_sel));
    // The one slave's ready is the bus ready.
    assign hready = hreadyout;
    // Clock at 250 MHz.
    always #2 hclk = ~hclk;
    // Collects each non-black word at a load, sampled away from the edge.
    always @(negedge hclk) begin
        if (dac_load === 1'b1 && {dac_red, dac_green, dac_blue} !== 24'h0) begin
            got.push_back({dac_red, dac_green, dac_blue});
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single transfer; ready is read in the cycle before each sampling edge.
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        logic ok;
        hsel <= 1'b1;
        htrans <= tcpu_pkg::HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= wr;
        do begin
            @(negedge hclk);
            ok = hready;
            @(posedge hclk);
        end while (ok !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge hclk);
            ok = hready;
            rd = hrdata;
            @(posedge hclk);
        end while (ok !== 1'b1);
    endtask
    // Sends a line and compares the colours that reached the DAC words.
    task automatic line(input string what, input logic [7:0] b[$], input bit dual,
        input logic [3:0] ovl, input logic [23:0] e[$]);
        got.delete();
        gfx.send(b, dual, ovl);
        repeat (100) @(posedge hclk);
        chk({what, " count"}, e.size(), got.size());
        foreach (e[i]) chk(what, e[i], got[i]);
        $display("test %s finished", what);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short well past the expected run of some 12 us.
    initial begin
        #100000;
        fails++;
        conclude();
    end
    // Register checks, then one line per colour mode, plus an overlay line in pseudocolour.
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 12'h000, 32'h0);
        chk("control reset", 32'h0, rd);
        ahb(1'b0, 12'h004, 32'h0);
        chk("mask reset", 32'h0000_00FF, rd);
        ahb(1'b0, 12'h800, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 12'h004, 32'h0000_00F0);
        ahb(1'b1, 12'h4C0, 32'h0012_3456);
        ahb(1'b1, 12'h680, 32'h00AB_CDEF);
        ahb(1'b1, 12'h048, 32'h000F_0F0F);
        line("pseudo", '{8'h3C, 8'hA5}, 1'b0, 4'h0, '{24'h123456, 24'hABCDEF});
        ahb(1'b1, 12'h000, 32'h0000_0060);
        ahb(1'b0, 12'h000, 32'h0);
        chk("control", 32'h0000_0060, rd);
        line("overlay", '{8'h3C}, 1'b0, 4'h3, '{24'h0F0F0F});
        ahb(1'b1, 12'h000, 32'h0000_00E0);
        line("mode7", '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77}, 1'b0, 4'h0,
            '{24'h332211, 24'h665544});
        ahb(1'b1, 12'h000, 32'h0000_00A0);
        line("mode5", '{8'h1F, 8'hFC, 8'hE0, 8'h03}, 1'b0, 4'h0,
            '{24'hF800F8, 24'h00F800});
        ahb(1'b1, 12'h000, 32'h0000_00C0);
        line("mode6", '{8'h1F, 8'hF8, 8'hE0, 8'h07}, 1'b0, 4'h0,
            '{24'hF800F8, 24'h00FC00});
        ahb(1'b1, 12'h000, 32'h0000_0080);
        line("mode4", '{8'h1F, 8'hFC, 8'hE0, 8'h03}, 1'b1, 4'h0,
            '{24'hF800F8, 24'h00F800});
        conclude();
    end
endmodule
`default_nettype wire
